//--- core/emtc_pkg.sv
// emtc_pkg: register map, field layout, reset values, phase states and
// fixed timing counts of the external memory bus timing block.
// assumes one system clock; all counts are in system clock cycles.
package emtc_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] EMTC_PAGE_OFS   = 8'hA8;
  localparam logic [7:0] EMTC_CFG_OFS    = 8'hA9;
  localparam logic [7:0] EMTC_TC_OFS     = 8'hAA;
  localparam logic [7:0] EMTC_STAT_OFS   = 8'hAB;

  // reset values and config write mask
  localparam logic [7:0] EMTC_TC_RST     = 8'hFF;
  localparam logic [7:0] EMTC_CFG_RST    = 8'h00;
  localparam logic [7:0] EMTC_PAGE_RST   = 8'h00;
  localparam logic [7:0] EMTC_CFG_MASK   = 8'h1F;

  // ext_mem_timing_ctrl fields
  localparam int EMTC_SETUP_LSB = 6;
  localparam int EMTC_WIDTH_LSB = 2;
  localparam int EMTC_HOLD_LSB  = 0;

  // ext_if_config fields
  localparam int EMTC_MUXSEL_BIT = 4;
  localparam int EMTC_MODE_LSB   = 2;
  localparam int EMTC_ALEW_LSB   = 0;

  // memory modes
  localparam logic [1:0] EMTC_MEM_INT    = 2'h0;
  localparam logic [1:0] EMTC_MEM_SPLIT  = 2'h1;
  localparam logic [1:0] EMTC_MEM_BANK   = 2'h2;
  localparam logic [1:0] EMTC_MEM_EXT    = 2'h3;

  // fixed overhead: one start cycle plus three closing cycles
  localparam logic [4:0] EMTC_START_CYC  = 5'h01;
  localparam logic [4:0] EMTC_FIN_CYC    = 5'h03;
  localparam logic [5:0] EMTC_OVERHEAD   = 6'h04;

  localparam int EMTC_CNT_W = 5;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_ALEH, ST_ALEL, ST_SETUP, ST_STROBE, ST_HOLD, ST_FIN
  } emtc_st_e;

endpackage

//--- core/emtc_tmr.sv
// emtc_tmr: down counter that times one bus phase.
// assumes load carries a phase length of at least one cycle.
`timescale 1ns/1ps
module emtc_tmr
  import emtc_pkg::*;
#(
  parameter int CNT_W = EMTC_CNT_W
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  emtc_tmr_if.tmr   tif
);

  if (CNT_W < EMTC_CNT_W) begin : g_chk
    $error("emtc_tmr: CNT_W too small for a 16 cycle phase");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } emtc_tmr_s;

  emtc_tmr_s st_ff;
  emtc_tmr_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (tif.load) begin
      nxt_st.cnt = CNT_W'(tif.val);
    end else if (st_ff.cnt != '0) begin
      nxt_st.cnt = st_ff.cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign tif.last = (st_ff.cnt == CNT_W'(1));

endmodule // emtc_tmr

//--- core/emtc_tmr_if.sv
// emtc_tmr_if: phase timer control between the sequencer and its timer.
// assumes both ends run on the same clock.
`timescale 1ns/1ps
interface emtc_tmr_if;
  import emtc_pkg::*;
  logic                  load;
  logic [EMTC_CNT_W-1:0] val;
  logic                  last;
  modport ctl (output load, output val, input last);
  modport tmr (input load, input val, output last);
endinterface

//--- core/emtc_top.sv
// emtc_top: external data memory bus sequencer with programmable timing.
// assumes move requests come from cpu logic on clk; ad_i comes from pins.
// Summary of operation
// R1: setup field bits 7:6 inserts 0..3 cycles before the strobe.
// R2: hold field bits 1:0 keeps address 0..3 cycles after the strobe.
// R3: strobe field bits 5:2 plus one gives strobe width 1..16 cycles.
// R4: address and control setup and hold programmable from zero to three cycles.
// R5: multiplexed moves hold latch enable high one to four cycles.
// R6: mode 101, 110, 111 run wide moves non-multiplexed.
// R7: mode 110 byte moves use page as upper byte, pointer as lower.
// R8: mode 001, 010, 011 run wide moves multiplexed on the shared port.
// R9: mode 001, 011 byte moves leave the upper address byte undriven.
// R10: config bit 4 selects multiplexed or non-multiplexed bus.
// R11: config bits 3:2 select internal, split, split with bank, external.
// R12: off-chip move takes programmed phases plus four cycles.
// R13: timing register resets to maximum setup, strobe and hold.
// R14: external memory answers within strobe; latch captures on falling enable.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module emtc_top
  import emtc_pkg::*;
#(
  parameter logic [15:0] INT_XRAM_SIZE = 16'h1000
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        mv_valid,
  input  wire logic        mv_write,
  input  wire logic        mv_wide,
  input  wire logic [15:0] mv_ptr,
  input  wire logic [7:0]  mv_wdata,
  output logic      [7:0]  mv_rdata,
  output logic             mv_done,
  output logic             mv_internal,
  output logic             busy,
  output logic      [7:0]  addr_hi,
  output logic             addr_hi_oe_n,
  output logic      [7:0]  addr_lo,
  output logic             addr_lo_oe_n,
  output logic      [7:0]  ad_o,
  output logic             ad_oe_n,
  input  wire logic [7:0]  ad_i,
  output logic             ale,
  output logic             rd_n,
  output logic             wr_n
);

  if (INT_XRAM_SIZE == 16'h0000) begin : g_chk
    $error("emtc_top: INT_XRAM_SIZE must be nonzero");
  end

  typedef struct packed {
    emtc_st_e    st;
    logic [7:0]  tc;
    logic [7:0]  cfg;
    logic [7:0]  page;
    logic [7:0]  tim_tc;
    logic [1:0]  tim_alew;
    logic        tim_mux;
    logic        write;
    logic        hi_drive;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [7:0]  reg_rdata;
    logic [7:0]  ad_s1;
    logic [7:0]  ad_s2;
    logic        cap_p1;
    logic        cap_p2;
    logic        done;
    logic        internal;
    logic        busy;
    logic        off_last;
    logic [7:0]  addr_hi;
    logic        addr_hi_oe_n;
    logic [7:0]  addr_lo;
    logic        addr_lo_oe_n;
    logic [7:0]  ad_o;
    logic        ad_oe_n;
    logic        ale;
    logic        rd_n;
    logic        wr_n;
  } emtc_top_s;

  localparam emtc_top_s TOP_RST = '{
    st: ST_IDLE, tc: EMTC_TC_RST, cfg: EMTC_CFG_RST, page: EMTC_PAGE_RST,
    tim_tc: EMTC_TC_RST, addr_hi_oe_n: 1'b1, addr_lo_oe_n: 1'b1, ad_oe_n: 1'b1,
    rd_n: 1'b1, wr_n: 1'b1, default: '0};

  emtc_top_s st_ff;
  emtc_top_s nxt_st;
  emtc_tmr_if tif ();

  emtc_tmr emtc_tmr_i (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .tif     (tif.tmr)
  );

  // cycles spent in a phase for the latched settings
  function automatic logic [4:0] phase_len(emtc_st_e ph, logic [7:0] tc, logic [1:0] alew);
    case (ph)
      ST_START:  phase_len = EMTC_START_CYC;
      ST_ALEH,
      ST_ALEL:   phase_len = {3'h0, alew} + 5'h01;                   // see R5
      ST_SETUP:  phase_len = {3'h0, tc[EMTC_SETUP_LSB +: 2]};          // see R1
      ST_STROBE: phase_len = {1'b0, tc[EMTC_WIDTH_LSB +: 4]} + 5'h01;  // see R3
      ST_HOLD:   phase_len = {3'h0, tc[EMTC_HOLD_LSB +: 2]};           // see R2
      ST_FIN:    phase_len = EMTC_FIN_CYC;                           // see R12
      default:   phase_len = 5'h00;
    endcase
  endfunction

  // zero length setup and hold phases are skipped
  function automatic emtc_st_e phase_after(emtc_st_e ph, logic [7:0] tc, logic mux);
    case (ph)
      ST_START:  phase_after = mux ? ST_ALEH : ((tc[EMTC_SETUP_LSB +: 2] != 2'h0) ? ST_SETUP : ST_STROBE);
      ST_ALEH:   phase_after = ST_ALEL;
      ST_ALEL:   phase_after = (tc[EMTC_SETUP_LSB +: 2] != 2'h0) ? ST_SETUP : ST_STROBE; // see R4
      ST_SETUP:  phase_after = ST_STROBE;
      ST_STROBE: phase_after = (tc[EMTC_HOLD_LSB +: 2] != 2'h0) ? ST_HOLD : ST_FIN;    // see R4
      ST_HOLD:   phase_after = ST_FIN;
      default:   phase_after = ST_IDLE;
    endcase
  endfunction

  logic [15:0] eff_addr;
  logic [1:0]  mem_mode;
  logic        off_chip;

  always_comb begin
    nxt_st = st_ff;
    tif.load = 1'b0;
    tif.val = '0;
    nxt_st.done = 1'b0;
    nxt_st.internal = 1'b0;
    nxt_st.reg_rdata = 8'h00;
    nxt_st.ad_s1 = ad_i;
    nxt_st.ad_s2 = st_ff.ad_s1;
    mem_mode = st_ff.cfg[EMTC_MODE_LSB +: 2];
    eff_addr = mv_wide ? mv_ptr : {st_ff.page, mv_ptr[7:0]};
    // see R11
    off_chip = (mem_mode == EMTC_MEM_EXT) ||
               ((mem_mode == EMTC_MEM_SPLIT || mem_mode == EMTC_MEM_BANK) && eff_addr >= INT_XRAM_SIZE);

    // register port
    if (reg_wr) begin
      if (reg_addr == EMTC_TC_OFS) begin
        nxt_st.tc = reg_wdata;
      end else if (reg_addr == EMTC_CFG_OFS) begin
        nxt_st.cfg = reg_wdata & EMTC_CFG_MASK;
      end else if (reg_addr == EMTC_PAGE_OFS) begin
        nxt_st.page = reg_wdata;
      end
    end
    if (reg_rd) begin
      if (reg_addr == EMTC_TC_OFS) begin
        nxt_st.reg_rdata = st_ff.tc;
      end else if (reg_addr == EMTC_CFG_OFS) begin
        nxt_st.reg_rdata = st_ff.cfg;
      end else if (reg_addr == EMTC_PAGE_OFS) begin
        nxt_st.reg_rdata = st_ff.page;
      end else if (reg_addr == EMTC_STAT_OFS) begin
        nxt_st.reg_rdata = {6'h00, st_ff.off_last, st_ff.busy};
      end
    end

    // move sequencer
    case (st_ff.st)
      ST_IDLE: begin
        if (mv_valid) begin
          if (off_chip) begin
            nxt_st.st = ST_START;
            tif.load = 1'b1;
            tif.val = EMTC_START_CYC;
            nxt_st.tim_tc = st_ff.tc;
            nxt_st.tim_alew = st_ff.cfg[EMTC_ALEW_LSB +: 2];
            nxt_st.tim_mux = ~st_ff.cfg[EMTC_MUXSEL_BIT];                  // see R10
            nxt_st.write = mv_write;
            nxt_st.addr = eff_addr;                                        // see R7
            nxt_st.wdata = mv_wdata;
            nxt_st.hi_drive = mv_wide || (mem_mode == EMTC_MEM_BANK);      // see R9
            nxt_st.off_last = 1'b1;
          end else begin
            nxt_st.done = 1'b1;
            nxt_st.internal = 1'b1;
            nxt_st.off_last = 1'b0;
          end
        end
      end
      default: begin
        if (tif.last) begin
          nxt_st.st = phase_after(st_ff.st, st_ff.tim_tc, st_ff.tim_mux);
          tif.load = 1'b1;
          tif.val = phase_len(nxt_st.st, st_ff.tim_tc, st_ff.tim_alew);
          nxt_st.done = (st_ff.st == ST_FIN);                              // see R12
        end
      end
    endcase

    // read data sampled as the strobe ends, two sync stages later
    nxt_st.cap_p1 = (st_ff.st == ST_STROBE) && (nxt_st.st != ST_STROBE) && !st_ff.write;
    nxt_st.cap_p2 = st_ff.cap_p1;
    if (st_ff.cap_p2) begin
      nxt_st.rdata = st_ff.ad_s2;
    end

    // pins follow the next phase so they come straight from flops
    nxt_st.busy = (nxt_st.st != ST_IDLE);
    nxt_st.addr_hi = st_ff.addr[15:8];
    nxt_st.addr_lo = st_ff.addr[7:0];
    if (nxt_st.st != ST_IDLE && nxt_st.st != ST_START) begin
      nxt_st.addr_hi = nxt_st.addr[15:8];
      nxt_st.addr_lo = nxt_st.addr[7:0];
    end else if (nxt_st.st == ST_START) begin
      nxt_st.addr_hi = nxt_st.addr[15:8];
      nxt_st.addr_lo = nxt_st.addr[7:0];
    end
    nxt_st.addr_hi_oe_n = !(nxt_st.busy && nxt_st.hi_drive);               // see R9
    nxt_st.addr_lo_oe_n = !(nxt_st.busy && !nxt_st.tim_mux);               // see R6
    nxt_st.ale = (nxt_st.st == ST_ALEH);                                   // see R5
    nxt_st.rd_n = !(nxt_st.st == ST_STROBE && !nxt_st.write);              // see R3
    nxt_st.wr_n = !(nxt_st.st == ST_STROBE && nxt_st.write);
    if (nxt_st.tim_mux && (nxt_st.st == ST_START || nxt_st.st == ST_ALEH || nxt_st.st == ST_ALEL)) begin
      nxt_st.ad_o = nxt_st.addr[7:0];                                      // see R8
      nxt_st.ad_oe_n = 1'b0;
    end else if (nxt_st.write && nxt_st.busy && nxt_st.st != ST_FIN) begin
      nxt_st.ad_o = nxt_st.wdata;
      nxt_st.ad_oe_n = 1'b0;
    end else begin
      nxt_st.ad_o = st_ff.ad_o;
      nxt_st.ad_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= TOP_RST;                                                    // see R13
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata    = st_ff.reg_rdata;
  assign mv_rdata     = st_ff.rdata;
  assign mv_done      = st_ff.done;
  assign mv_internal  = st_ff.internal;
  assign busy         = st_ff.busy;
  assign addr_hi      = st_ff.addr_hi;
  assign addr_hi_oe_n = st_ff.addr_hi_oe_n;
  assign addr_lo      = st_ff.addr_lo;
  assign addr_lo_oe_n = st_ff.addr_lo_oe_n;
  assign ad_o         = st_ff.ad_o;
  assign ad_oe_n      = st_ff.ad_oe_n;
  assign ale          = st_ff.ale;
  assign rd_n         = st_ff.rd_n;
  assign wr_n         = st_ff.wr_n;

  // helper counters for the checks below
  logic [4:0] ph_cnt_ff;
  logic [5:0] cyc_ff;
  logic [5:0] exp_cyc;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph_cnt_ff <= 5'h00;
      cyc_ff <= 6'h00;
    end else if (ce) begin
      ph_cnt_ff <= (nxt_st.st != st_ff.st) ? 5'h01 : ph_cnt_ff + 5'h01;
      cyc_ff <= (st_ff.st == ST_IDLE) ? 6'h00 : cyc_ff + 6'h01;
    end
  end

  assign exp_cyc = (st_ff.tim_mux ? {3'h0, st_ff.tim_alew, 1'b0} + 6'h02 : 6'h00)
                 + {4'h0, st_ff.tim_tc[EMTC_SETUP_LSB +: 2]} + {2'h0, st_ff.tim_tc[EMTC_WIDTH_LSB +: 4]}
                 + 6'h01 + {4'h0, st_ff.tim_tc[EMTC_HOLD_LSB +: 2]} + EMTC_OVERHEAD;

  default clocking cb @(posedge clk iff ce); endclocking
  default disable iff (sys_rst);

  setup_len_a: assert property ((st_ff.st == ST_SETUP && nxt_st.st != ST_SETUP) |-> // see R1
    ph_cnt_ff == {3'h0, st_ff.tim_tc[EMTC_SETUP_LSB +: 2]}) else $error("setup phase length wrong");
  hold_len_a: assert property ((st_ff.st == ST_HOLD && nxt_st.st != ST_HOLD) |-> // see R2
    ph_cnt_ff == {3'h0, st_ff.tim_tc[EMTC_HOLD_LSB +: 2]}) else $error("hold phase length wrong");
  strobe_len_a: assert property ((st_ff.st == ST_STROBE && nxt_st.st != ST_STROBE) |-> // see R3
    ph_cnt_ff == {1'b0, st_ff.tim_tc[EMTC_WIDTH_LSB +: 4]} + 5'h01) else $error("strobe width wrong");
  ale_width_a: assert property ($fell(ale) |-> // see R5
    $past(ph_cnt_ff) == {3'h0, st_ff.tim_alew} + 5'h01) else $error("latch enable width wrong");
  nomux_ale_a: assert property (!st_ff.tim_mux |-> !ale) else $error("latch enable in non-multiplexed mode"); // see R6
  bank_page_a: assert property ((busy && !addr_hi_oe_n && !st_ff.tim_mux && st_ff.hi_drive) |-> // see R7
    addr_hi == st_ff.addr[15:8]) else $error("upper address byte wrong");
  nobank_hi_a: assert property ($rose(busy) && !$past(mv_wide) && // see R9
    $past(st_ff.cfg[EMTC_MODE_LSB +: 2]) != EMTC_MEM_BANK |-> addr_hi_oe_n [*2])
    else $error("upper address driven without bank select");
  mux_addr_a: assert property ($rose(ale) |-> !ad_oe_n && ad_o == st_ff.addr[7:0]) // see R8
    else $error("shared port not carrying low address");
  move_len_a: assert property ((mv_done && !mv_internal) |-> cyc_ff == exp_cyc) // see R12
    else $error("off-chip move length wrong");
  strobe_excl_a: assert property (!(rd_n == 1'b0 && wr_n == 1'b0)) else $error("both strobes low"); // see R4

endmodule // emtc_top

//--- verif/emtc_sram_mdl.sv
// emtc_sram_mdl: external asynchronous memory with an address latch.
// assumes strobes and latch enable are launched on clk by the bus master.
`timescale 1ns/1ps
module emtc_sram_mdl (
  input  wire logic       clk,
  input  wire logic [1:0] slow,
  input  wire logic [7:0] addr_hi,
  input  wire logic       addr_hi_oe_n,
  input  wire logic [7:0] addr_lo,
  input  wire logic       addr_lo_oe_n,
  input  wire logic [7:0] ad_o,
  input  wire logic       ale,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  output logic      [7:0] ad_i
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  lat  = 8'h00;
  logic [7:0]  last = 8'h00;
  logic [4:0]  scnt = 5'h00;
  logic [15:0] a;
  // undriven upper pins read as zero; undriven lower pins read from the address latch
  assign a = {addr_hi_oe_n ? 8'h00 : addr_hi, addr_lo_oe_n ? lat : addr_lo};
  always @(posedge clk) begin
    if (ale) lat <= ad_o;
    if (!wr_n) mem[a] <= ad_o;
    if (!rd_n) last <= ad_i;
    scnt <= rd_n ? 5'h00 : scnt + 5'h01;
  end
  // slow part shows garbage until its access time runs out
  assign ad_i = (!rd_n && scnt >= {3'h0, slow}) ? mem[a] : ~last;
endmodule // emtc_sram_mdl

//--- verif/emtc_top_tb.sv
// emtc_top_tb: register and move tests of the external memory bus timing block.
// assumes emtc_pkg, the design and the memory model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module emtc_top_tb;
  import emtc_pkg::*;
  logic        clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        mv_valid = 1'b0, mv_write = 1'b0, mv_wide = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, mv_wdata = 8'h00, ad_i;
  logic [15:0] mv_ptr = 16'h0000;
  logic [7:0]  reg_rdata, mv_rdata, addr_hi, addr_lo, ad_o, hi;
  logic        mv_done, mv_internal, busy, addr_hi_oe_n, addr_lo_oe_n, ad_oe_n, ale, rd_n, wr_n;
  logic        hi_oe, lo_oe, ad_oe, ce = 1'b1;
  logic [7:0]  tc = EMTC_TC_RST, cf = EMTC_CFG_RST, pg = EMTC_PAGE_RST;
  logic [1:0]  slow = 2'h0;
  int          n_fail = 0, check_count = 0, cyc = 0, n_str = 0, n_ale = 0, n_busy = 0;
  logic [7:0]  tcs [4] = '{8'h00, 8'hFF, 8'h5A, 8'hA5};
  logic [7:0]  cfs [5] = '{8'h1C, 8'h18, 8'h0C, 8'h0B, 8'h04};

  emtc_top emtc_top_i (.clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mv_valid(mv_valid), .mv_write(mv_write),
    .mv_wide(mv_wide), .mv_ptr(mv_ptr), .mv_wdata(mv_wdata), .mv_rdata(mv_rdata), .mv_done(mv_done),
    .mv_internal(mv_internal), .busy(busy), .addr_hi(addr_hi), .addr_hi_oe_n(addr_hi_oe_n),
    .addr_lo(addr_lo), .addr_lo_oe_n(addr_lo_oe_n), .ad_o(ad_o), .ad_oe_n(ad_oe_n), .ad_i(ad_i),
    .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
  emtc_sram_mdl emtc_sram_mdl_i (.clk(clk), .slow(slow), .addr_hi(addr_hi), .addr_hi_oe_n(addr_hi_oe_n),
    .addr_lo(addr_lo), .addr_lo_oe_n(addr_lo_oe_n), .ad_o(ad_o), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
    .ad_i(ad_i));

  always #4 clk = ~clk;

  task automatic close_out;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // pin monitor: strobe and latch widths, address drive during strobe
  always @(posedge clk) begin
    cyc++;
    if (!rd_n || !wr_n) begin
      n_str++;
      hi_oe = addr_hi_oe_n;
      lo_oe = addr_lo_oe_n;
      ad_oe = ad_oe_n;
      hi = addr_hi;
    end
    if (ale) n_ale++;
    if (busy) n_busy++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk) reg_wr <= 1'b0;
    if (a == EMTC_TC_OFS) tc = d;
    if (a == EMTC_CFG_OFS) cf = d & EMTC_CFG_MASK;
    if (a == EMTC_PAGE_OFS) pg = d;
    slow <= (tc[5:2] != 4'h0) ? 2'h2 : 2'h0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk) reg_rd <= 1'b0;
    #1 `CHK("reg_rdata", e, reg_rdata)
    @(posedge clk);
  endtask

  task automatic mv(input logic w, input logic wd, input logic [15:0] p, input logic [7:0] d,
                    input logic intl, input logic [7:0] e);
    int   n, k;
    logic mux;
    mux = !cf[EMTC_MUXSEL_BIT];
    n = intl ? 0 : 1 + (mux ? 2 * (cf[1:0] + 1) : 0) + tc[7:6] + tc[5:2] + 1 + tc[1:0] + 3;
    n_str = 0; n_ale = 0; n_busy = 0; k = 0;
    mv_write <= w; mv_wide <= wd; mv_ptr <= p; mv_wdata <= d; mv_valid <= 1'b1;
    do begin
      @(posedge clk) mv_valid <= 1'b0;
      k++;
      #1;
    end while (mv_done !== 1'b1 && k < 60);
    `CHK("move cycles", n + 1, k)
    `CHK("internal", intl, mv_internal)
    `CHK("busy cycles", n, n_busy)
    if (!intl) begin
      `CHK("data port drive", !w, ad_oe)
      `CHK("strobe width", tc[5:2] + 5'd1, n_str)
      `CHK("ale width", mux ? cf[1:0] + 3'd1 : 3'd0, n_ale)
      `CHK("low addr pins", mux, lo_oe)
      `CHK("high addr pins", !(wd || cf[3:2] == EMTC_MEM_BANK), hi_oe)
      if (!wd && cf[3:2] == EMTC_MEM_BANK) `CHK("page byte", pg, hi)
      if (!w) `CHK("read data", e, mv_rdata)
    end
    @(posedge clk);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(EMTC_TC_OFS, EMTC_TC_RST);
    rd(EMTC_CFG_OFS, 8'h00);
    rd(8'h00, 8'h00);
    wr(EMTC_CFG_OFS, 8'hFF);
    rd(EMTC_CFG_OFS, 8'h1F);
    wr(EMTC_CFG_OFS, 8'h00);
    mv(1'b1, 1'b1, 16'h4000, 8'h11, 1'b1, 8'h00);
    rd(EMTC_STAT_OFS, 8'h00);
    // clock enable low: the write must be ignored
    ce <= 1'b0;
    wr(EMTC_PAGE_OFS, 8'h33);
    ce <= 1'b1;
    rd(EMTC_PAGE_OFS, EMTC_PAGE_RST);
    wr(EMTC_PAGE_OFS, 8'h80);
    rd(EMTC_PAGE_OFS, 8'h80);
    // split mode: boundary decides on-chip or off-chip
    wr(EMTC_CFG_OFS, 8'h14);
    mv(1'b1, 1'b1, 16'h0FFF, 8'h22, 1'b1, 8'h00);
    mv(1'b1, 1'b1, 16'h1000, 8'h5A, 1'b0, 8'h00);
    mv(1'b0, 1'b1, 16'h1000, 8'h00, 1'b0, 8'h5A);
    rd(EMTC_STAT_OFS, 8'h02);
    // four timing codes against five bus configurations
    foreach (tcs[i]) begin
      foreach (cfs[j]) begin
        wr(EMTC_TC_OFS, tcs[i]);
        wr(EMTC_CFG_OFS, cfs[j]);
        rd(EMTC_TC_OFS, tcs[i]);
        mv(1'b1, 1'b1, 16'h9000 + 16'(j), 8'(i * 16 + j + 1), 1'b0, 8'h00);
        mv(1'b1, 1'b0, 16'h0040 + 16'(j), 8'(i * 16 + j + 129), 1'b0, 8'h00);
        mv(1'b0, 1'b1, 16'h9000 + 16'(j), 8'h00, 1'b0, 8'(i * 16 + j + 1));
        mv(1'b0, 1'b0, 16'h0040 + 16'(j), 8'h00, 1'b0, 8'(i * 16 + j + 129));
      end
    end
    // mid-run reset brings back maximum timing
    sys_rst <= 1'b1;
    @(posedge clk) sys_rst <= 1'b0;
    @(posedge clk);
    rd(EMTC_TC_OFS, EMTC_TC_RST);
    rd(EMTC_CFG_OFS, EMTC_CFG_RST);
    close_out();
  end
endmodule // emtc_top_tb
